/* File: pkg/rx_cdr_lock_map.svh */
// register map, field positions, reset values and counts of the receive lock and clock block
`ifndef RX_CDR_LOCK_MAP_SVH
`define RX_CDR_LOCK_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_IRQ_STATUS  4'h8
`define OFS_IRQ_MASK    4'hc
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_QUAL_BIT   0
`define CTRL_FORCE_LSB  1
`define CTRL_RATE_LSB   3
`define CTRL_TRIP_LSB   5
`define CTRL_RESET      32'h0000_0007
`define IRQ_MASK_RESET  32'h0000_0000
// ----------------------------------------
// status fields, five bits per channel
// ----------------------------------------
`define STAT_STRIDE     5
// ----------------------------------------
// detector limits and character framing
// ----------------------------------------
`define DENSITY_LIMIT   6'h3c
`define CHAR_LAST       4'h9
`define CHAR_HALF       4'h4
`define TRIP_LEVEL0     4'h2
`define TRIP_LEVEL1     4'h4
`define TRIP_LEVEL2     4'h8
`define TRIP_LEVEL3     4'hc
`endif

/* File: pkg/rx_cdr_lock_pkg.sv */
// types of the receive lock and clock block
package rx_cdr_lock_pkg;
  typedef enum logic [1:0]
  {
    LOCK_TRAINING = 2'b01,
    LOCK_TRACKING = 2'b10
  } lock_state_type;
  typedef logic [1:0][3:0] amp_pair_type;
  typedef logic [1:0][9:0] data_pair_type;
endpackage

/* File: verilog/rx_cdr_lock_and_clock_control.sv */
// receive lock selection, receive clock generation and link fault logic for two channels
// Notes on behaviour
// - receive pll uses training clock as reference
// - recovered clock derived from serial data alone
// - interface clock at bit rate over 10/20
// - parallel data timed by true/complement interface clock
// - reclocker clock equal or twice interface clock
// - reclocker clock phase need not match interface
// - reset initialises all state, counters, latches
// - qualifier high: any detector fails, hold training
// - density fails without transition in 60 bits
// - qualifier low: range controller alone decides
// - two-bit trip select sets level threshold
// - force local lock low selects training clock
// - force local lock low drives fault low
// - force local lock high allows data recovery
// - active-low fault on any fault condition
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "rx_cdr_lock_map.svh"
module rx_cdr_lock_and_clock_control
(
  // clock, reset, enable
  input  wire logic                           clk,
  input  wire logic                           srst,
  input  wire logic                           ce,
  // axi4-lite write
  input  wire logic [3:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // serial side, per channel
  input  wire logic [1:0]                     rx_bit_valid,
  input  wire logic [1:0]                     rx_serial_bit,
  input  wire logic [1:0]                     range_in_limits,
  input  wire rx_cdr_lock_pkg::amp_pair_type  signal_amplitude,
  // pll control and host side per channel, and the shared interrupt
  output logic [1:0]                          pll_tracks_data,
  output logic [1:0]                          recovered_rx_clock,
  output logic [1:0]                          recovered_rx_clock_n,
  output logic [1:0]                          reclocker_clock_out,
  output rx_cdr_lock_pkg::data_pair_type      rx_parallel_data,
  output logic [1:0]                          link_fault_indicator_n,
  output logic                                irq
);
  import rx_cdr_lock_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [3:0] trip_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trip_level = `TRIP_LEVEL0;
      2'h1:    trip_level = `TRIP_LEVEL1;
      2'h2:    trip_level = `TRIP_LEVEL2;
      default: trip_level = `TRIP_LEVEL3;
    endcase
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0]          ctrl_r;
  logic [31:0]          irq_status_r;
  logic [31:0]          irq_mask_r;
  logic [31:0]          irq_status_nxt;
  logic                 aw_held_r;
  logic                 w_held_r;
  logic [3:0]           awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  lock_state_type       state_r [2];
  lock_state_type       state_nxt [2];
  logic [5:0]           run_r [2];
  logic [1:0]           prev_bit_r;
  logic [3:0]           bit_cnt_r [2];
  logic [9:0]           shift_r [2];
  logic [31:0]          status_word;
  logic [1:0]           level_ok;
  logic [1:0]           density_ok;
  logic [1:0]           want_data;
  logic [1:0]           fault_now;
  logic [3:0]           events;
  logic [31:0]          wmask;
  logic [31:0]          rd_word;
  logic                 rd_hit;
  logic                 do_write;

  wire qual_en = ctrl_r[`CTRL_QUAL_BIT];
  wire [1:0] force_high = ctrl_r[`CTRL_FORCE_LSB +: 2];
  wire [1:0] rate_sel = ctrl_r[`CTRL_RATE_LSB +: 2];
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // ----------------------------------------
  // detectors and lock decision
  // ----------------------------------------
  // every per-channel term indexes only its own channel
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
      assign level_ok[c] = signal_amplitude[c] >= trip_level(ctrl_r[`CTRL_TRIP_LSB + 2*c +: 2]);
      assign density_ok[c] = run_r[c] < `DENSITY_LIMIT;
      // the qualifier only widens the set of detectors; the range controller always votes
      assign want_data[c] = force_high[c] &&
                            (qual_en ? (range_in_limits[c] && level_ok[c] && density_ok[c])
                                     : range_in_limits[c]);
      assign state_nxt[c] = want_data[c] ? LOCK_TRACKING : LOCK_TRAINING;
      assign fault_now[c] = !force_high[c] || !range_in_limits[c] || !level_ok[c] || !density_ok[c];
      assign events[2*c] = want_data[c] && state_r[c] == LOCK_TRAINING;
      assign events[2*c+1] = fault_now[c] && link_fault_indicator_n[c];
      assign status_word[`STAT_STRIDE*c +: `STAT_STRIDE] =
        {fault_now[c], density_ok[c], level_ok[c], range_in_limits[c], pll_tracks_data[c]};
    end
  endgenerate
  assign status_word[31:2*`STAT_STRIDE] = '0;

  // ----------------------------------------
  // lock state, density counters, clocks
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int c = 0; c < 2; c++)
      begin
        state_r[c]   <= LOCK_TRAINING;
        run_r[c]     <= 6'h01;
        bit_cnt_r[c] <= 4'h0;
        shift_r[c]   <= 10'h000;
      end
      prev_bit_r             <= 2'h0;
      pll_tracks_data        <= 2'h0;
      link_fault_indicator_n <= 2'h0;
      recovered_rx_clock     <= 2'h0;
      recovered_rx_clock_n   <= 2'h3;
      reclocker_clock_out    <= 2'h0;
      rx_parallel_data       <= '0;
    end
    else if (ce)
    begin
      for (int c = 0; c < 2; c++)
      begin
        state_r[c]                <= state_nxt[c];
        pll_tracks_data[c]        <= state_nxt[c] == LOCK_TRACKING;
        link_fault_indicator_n[c] <= !fault_now[c];
        if (rx_bit_valid[c])
        begin
          prev_bit_r[c] <= rx_serial_bit[c];
          if (rx_serial_bit[c] != prev_bit_r[c])
            run_r[c] <= 6'h01;
          else if (run_r[c] < `DENSITY_LIMIT)
            run_r[c] <= run_r[c] + 6'h01;
          shift_r[c] <= {rx_serial_bit[c], shift_r[c][9:1]};
          if (bit_cnt_r[c] == `CHAR_LAST)
          begin
            bit_cnt_r[c]           <= 4'h0;
            rx_parallel_data[c]    <= {rx_serial_bit[c], shift_r[c][9:1]};
            reclocker_clock_out[c] <= 1'b1;
            // full rate: rising edge per character; half rate: one edge per character
            recovered_rx_clock[c]   <= rate_sel[c] ? !recovered_rx_clock[c] : 1'b1;
            recovered_rx_clock_n[c] <= rate_sel[c] ? recovered_rx_clock[c] : 1'b0;
          end
          else
          begin
            bit_cnt_r[c] <= bit_cnt_r[c] + 4'h1;
            if (bit_cnt_r[c] == `CHAR_HALF)
            begin
              reclocker_clock_out[c] <= 1'b0;
              if (!rate_sel[c])
              begin
                recovered_rx_clock[c]   <= 1'b0;
                recovered_rx_clock_n[c] <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------
  assign irq_status_nxt = (irq_status_r & ~((do_write && awaddr_r == `OFS_IRQ_STATUS) ? (wdata_r & wmask) : 32'h0))
                          | {28'h0, events};

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign rd_hit = s_axi_araddr == `OFS_CTRL || s_axi_araddr == `OFS_STATUS ||
                  s_axi_araddr == `OFS_IRQ_STATUS || s_axi_araddr == `OFS_IRQ_MASK;
  assign rd_word = s_axi_araddr == `OFS_CTRL       ? ctrl_r :
                   s_axi_araddr == `OFS_STATUS     ? status_word :
                   s_axi_araddr == `OFS_IRQ_STATUS ? irq_status_r :
                   s_axi_araddr == `OFS_IRQ_MASK   ? irq_mask_r : 32'h0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r        <= `CTRL_RESET;
      irq_mask_r    <= `IRQ_MASK_RESET;
      irq_status_r  <= 32'h0;
      irq           <= 1'b0;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
    end
    else if (ce)
    begin
      irq_status_r  <= irq_status_nxt;
      irq           <= |(irq_status_nxt & irq_mask_r);
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == `OFS_CTRL || awaddr_r == `OFS_IRQ_STATUS || awaddr_r == `OFS_IRQ_MASK)
                        ? 2'h0 : 2'h2;
        if (awaddr_r == `OFS_CTRL)
          ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
        if (awaddr_r == `OFS_IRQ_MASK)
          irq_mask_r <= (irq_mask_r & ~wmask) | (wdata_r & wmask);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_force_train;
    ce && !force_high[0] |=> !pll_tracks_data[0];
  endproperty
  a_force_train: assert property (p_force_train) else $error("forced channel left training");

  property p_force_fault;
    ce && !force_high[1] |=> !link_fault_indicator_n[1];
  endproperty
  a_force_fault: assert property (p_force_fault) else $error("fault not shown under force");

  property p_qual_hold;
    ce && qual_en && (!level_ok[0] || !density_ok[0]) |=> !pll_tracks_data[0];
  endproperty
  a_qual_hold: assert property (p_qual_hold) else $error("tracked data with failed detector");

  property p_range_only;
    ce && !qual_en && force_high[1] && range_in_limits[1] |=> pll_tracks_data[1];
  endproperty
  a_range_only: assert property (p_range_only) else $error("range alone did not select data");

  property p_density;
    ce && run_r[0] >= `DENSITY_LIMIT |-> !density_ok[0] ##1 !link_fault_indicator_n[0];
  endproperty
  a_density: assert property (p_density) else $error("density limit not enforced");

  property p_range_fault;
    ce && !range_in_limits[0] |=> !link_fault_indicator_n[0];
  endproperty
  a_range_fault: assert property (p_range_fault) else $error("range fault not indicated");

  property p_pair;
    $changed(recovered_rx_clock[0]) |-> recovered_rx_clock_n[0] == !recovered_rx_clock[0];
  endproperty
  a_pair: assert property (p_pair) else $error("interface clock pair not complementary");

  property p_reclk_rate;
    ce && rx_bit_valid[0] && bit_cnt_r[0] == `CHAR_LAST |=>
      reclocker_clock_out[0] && rx_parallel_data[0][9] == $past(rx_serial_bit[0]);
  endproperty
  a_reclk_rate: assert property (p_reclk_rate) else $error("reclocker clock missed character edge");

  property p_full_rate;
    ce && !rate_sel[0] && rx_bit_valid[0] && bit_cnt_r[0] == `CHAR_HALF |=> !recovered_rx_clock[0];
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate clock missed falling edge");

  property p_irq;
    ce |=> irq == |(irq_status_r & $past(irq_mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised for unmasked status");

endmodule

/* File: verification/serial_source.sv */
// serial line source model: one bit every other cycle, alternating or stuck
`timescale 1ns/1ps
module serial_source
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control from the bench
  input  wire logic [1:0] active,
  input  wire logic [1:0] stuck,
  // serial side
  output logic [1:0]      rx_bit_valid,
  output logic [1:0]      rx_serial_bit
);
  logic [1:0] last_r;
  logic [1:0] send;
  logic [1:0] next_bit;
  assign send     = active & ~rx_bit_valid;
  assign next_bit = (stuck & last_r) | (~stuck & ~last_r);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_bit_valid  <= 2'h0;
      rx_serial_bit <= 2'h0;
      last_r        <= 2'h0;
    end
    else
    begin
      rx_bit_valid  <= send;
      // between bits the line wanders, so a stale bit is never mistaken for data
      rx_serial_bit <= (send & next_bit) | (~send & ~rx_serial_bit);
      last_r        <= (send & next_bit) | (~send & last_r);
    end
  end
endmodule

/* File: verification/tb_rx_cdr_lock_and_clock_control.sv */
// self-checking bench of the receive lock and clock block
`timescale 1ns/1ps
`include "rx_cdr_lock_map.svh"
module tb_rx_cdr_lock_and_clock_control;
  import rx_cdr_lock_pkg::*;
  logic          clk, srst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, clk_chk;
  logic [3:0]    s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, ctl, rd;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rx_bit_valid, rx_serial_bit, range_in_limits, pll_tracks_data;
  logic [1:0]    recovered_rx_clock, recovered_rx_clock_n, reclocker_clock_out, link_fault_indicator_n;
  logic [1:0]    active, stuck, dn;
  amp_pair_type  signal_amplitude;
  data_pair_type rx_parallel_data;
  int            err_count, compares, cyc, seed, cnt[2];
  logic [9:0]    sr[2], ed[2];
  logic          erx[2], erc[2];
  logic [3:0]    thr[4];

  rx_cdr_lock_and_clock_control dut_u
  (
    .clk(clk), .srst(srst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_bit_valid(rx_bit_valid), .rx_serial_bit(rx_serial_bit), .range_in_limits(range_in_limits),
    .signal_amplitude(signal_amplitude), .pll_tracks_data(pll_tracks_data),
    .recovered_rx_clock(recovered_rx_clock), .recovered_rx_clock_n(recovered_rx_clock_n),
    .reclocker_clock_out(reclocker_clock_out), .rx_parallel_data(rx_parallel_data),
    .link_fault_indicator_n(link_fault_indicator_n), .irq(irq)
  );
  serial_source src_u (.clk(clk), .srst(srst), .active(active), .stuck(stuck),
                       .rx_bit_valid(rx_bit_valid), .rx_serial_bit(rx_serial_bit));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    cmp("bresp", (a == `OFS_CTRL || a == `OFS_IRQ_STATUS || a == `OFS_IRQ_MASK) ? 2'b00 : 2'b10, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    cmp("rresp", (a[1:0] == 2'b00) ? 2'b00 : 2'b10, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // expected decision worked out from inputs, control shadow and density state
  task automatic chk_dec();
    logic [1:0]  lv, tr, fn;
    logic [31:0] st;
    st = 32'h0;
    for (int c = 0; c < 2; c++)
    begin
      lv[c] = signal_amplitude[c] >= thr[ctl[5+2*c +: 2]];
      fn[c] = ctl[1+c] && range_in_limits[c] && lv[c] && dn[c];
      tr[c] = ctl[1+c] && (ctl[0] ? range_in_limits[c] && lv[c] && dn[c] : range_in_limits[c]);
      st = st | ({27'h0, !fn[c], dn[c], lv[c], range_in_limits[c], tr[c]} << (5*c));
    end
    cmp("tracks", tr, pll_tracks_data);
    cmp("fault_n", fn, link_fault_indicator_n);
    axi_rd(`OFS_STATUS, rd);
    cmp("status", st, rd & 32'h3ff);
  endtask

  task automatic stuck_bits(input int n);
    int k;
    k = 0;
    active <= 2'b11;
    while (k < n)
    begin
      @(posedge clk);
      if (rx_bit_valid[0] === 1'b1) k++;
    end
    active <= 2'b10;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------
  // character model checked at every received bit, clock model only while clk_chk is set
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      test_done();
    end
  end

  always @(posedge clk)
  begin
    if (srst)
      for (int c = 0; c < 2; c++)
      begin
        cnt[c] = 0;
        sr[c] = 10'h0;
        ed[c] = 10'h0;
        erx[c] = 1'b0;
        erc[c] = 1'b0;
      end
    else
      for (int c = 0; c < 2; c++)
        if (rx_bit_valid[c] === 1'b1)
        begin
          cmp("rx_data", ed[c], rx_parallel_data[c]);
          if (clk_chk)
          begin
            cmp("rx_clock", erx[c], recovered_rx_clock[c]);
            cmp("rx_clock_n", !erx[c], recovered_rx_clock_n[c]);
            cmp("reclocker", erc[c], reclocker_clock_out[c]);
          end
          sr[c] = {rx_serial_bit[c], sr[c][9:1]};
          if (cnt[c] % 10 == 9)
          begin
            ed[c] = sr[c];
            erc[c] = 1'b1;
            erx[c] = ctl[3+c] ? !erx[c] : 1'b1;
          end
          if (cnt[c] % 10 == 4)
          begin
            erc[c] = 1'b0;
            if (!ctl[3+c]) erx[c] = 1'b0;
          end
          cnt[c]++;
        end
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    {active, stuck, range_in_limits, signal_amplitude} = 14'h0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1;
    srst = 1'b1;
    seed = 32'he0b0;
    ctl = `CTRL_RESET;
    clk_chk = 1'b1;
    dn = 2'b11;
    thr = '{`TRIP_LEVEL0, `TRIP_LEVEL1, `TRIP_LEVEL2, `TRIP_LEVEL3};
    repeat (12) @(posedge clk);
    cmp("tracks_rst", 0, pll_tracks_data);
    cmp("fault_rst", 0, link_fault_indicator_n);
    cmp("clock_n_rst", 3, recovered_rx_clock_n);
    cmp("irq_rst", 0, irq);
    cmp("outs_rst", 0, {recovered_rx_clock, reclocker_clock_out, rx_parallel_data});
    srst <= 1'b0;
    active <= 2'b11;
    signal_amplitude <= 8'hff;
    range_in_limits <= 2'b11;
    axi_rd(`OFS_CTRL, rd);
    cmp("ctrl_rst", `CTRL_RESET, rd);
    axi_rd(`OFS_IRQ_MASK, rd);
    cmp("mask_rst", `IRQ_MASK_RESET, rd);
    // an unmapped word answers with an error and leaves control untouched
    axi_wr(4'h6, 32'hffff_ffff);
    axi_rd(4'h6, rd);
    cmp("unmapped", 0, rd);
    axi_rd(`OFS_CTRL, rd);
    cmp("ctrl_kept", `CTRL_RESET, rd);
    repeat (120) @(posedge clk);
    chk_dec();
    // line paused while the rate changes, so no bit lands on the update edge
    active <= 2'b00;
    repeat (4) @(posedge clk);
    ctl = 32'h17;
    axi_wr(`OFS_CTRL, ctl);
    active <= 2'b11;
    repeat (160) @(posedge clk);
    clk_chk = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      ctl = 32'($random(seed)) & 32'h1ff;
      range_in_limits <= 2'($random(seed));
      signal_amplitude <= 8'($random(seed));
      axi_wr(`OFS_CTRL, ctl);
      repeat (3) @(posedge clk);
      chk_dec();
      axi_rd(`OFS_CTRL, rd);
      cmp("ctrl", ctl, rd);
    end
    range_in_limits <= 2'b11;
    signal_amplitude <= 8'hff;
    ctl = 32'h7;
    axi_wr(`OFS_CTRL, ctl);
    active <= 2'b10;
    repeat (4) @(posedge clk);
    stuck <= 2'b01;
    stuck_bits(58);
    chk_dec();
    stuck_bits(1);
    dn = 2'b10;
    chk_dec();
    ctl = 32'h6;
    axi_wr(`OFS_CTRL, ctl);
    repeat (3) @(posedge clk);
    chk_dec();
    stuck <= 2'b00;
    active <= 2'b11;
    repeat (20) @(posedge clk);
    dn = 2'b11;
    ctl = 32'h7;
    axi_wr(`OFS_CTRL, ctl);
    repeat (3) @(posedge clk);
    chk_dec();
    range_in_limits <= 2'b10;
    repeat (3) @(posedge clk);
    axi_wr(`OFS_IRQ_STATUS, 32'hf);
    axi_wr(`OFS_IRQ_MASK, 32'h0);
    range_in_limits <= 2'b11;
    repeat (3) @(posedge clk);
    cmp("irq_masked", 0, irq);
    axi_rd(`OFS_IRQ_STATUS, rd);
    cmp("irq_status", 1, rd & 32'h1);
    axi_wr(`OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    cmp("irq_set", 1, irq);
    axi_wr(`OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    cmp("irq_clear", 0, irq);
    // clock enable low must freeze the lock decision; line paused so the bit model stays aligned
    active <= 2'b00;
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    range_in_limits <= 2'b00;
    repeat (3) @(posedge clk);
    cmp("ce_hold", 3, pll_tracks_data);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("ce_run", 0, pll_tracks_data);
    test_done();
  end
endmodule
